//--- startup_defs.svh
/*
  Constants of the start-up sequencer: phase codes, selector codes, defaults.
  Assumes it is included by its bare name wherever the codes are needed.
*/
// Contract
// - Write-enable phase 1..6, default 6, enables storage
// - Write-enable wait mode holds until completion high
// - Retain code keeps current write-enable phase
// - Output-release phase 1..6, default 5, frees outputs
// - Output-release wait mode holds until completion high
// - Retain code keeps current output-release phase
// - No-lock-wait default ignores clock manager locks
// - Lock phase 0..6 stalls until flagged locks
// - Passive mode releases completion pin, pull-up lifts
// - Active mode drives completion pin high
// - Pipeline off: completion input unregistered
// - Pipeline on: one register stage inserted
// - Pipeline on: release on first step after high
// - Completion phase 1..6, default 4, releases pin
// - Step clock: config, fabric or test clock
// - Default: hold released after completion, enable after
`ifndef STARTUP_DEFS_SVH
`define STARTUP_DEFS_SVH

`define PHASE_W          3
`define PHASE_FIRST      3'h0
`define PHASE_LAST_SEL   3'h6
`define PHASE_END        3'h7
`define SEL_KEEP         3'h0
`define SEL_WAIT_DONE    3'h7
`define LOCK_NO_WAIT     3'h7
`define WE_PHASE_RESET   3'h6
`define OR_PHASE_RESET   3'h5
`define CP_PHASE_RESET   3'h4
`define LOCK_SEL_RESET   3'h7

`endif

//--- startup_pkg.sv
/*
  Types shared by the start-up sequencer modules.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package startup_pkg;
  typedef enum logic [1:0] {seq_clk_config, seq_clk_fabric, seq_clk_jtag} seq_clk_e;
  typedef enum logic [1:0] {st_idle, st_run, st_user} seq_state_e;
endpackage : startup_pkg
`default_nettype wire

//--- startup_link_if.sv
/*
  Carrier between the sequencer and its step and completion-input helpers.
  Assumes all parties run on the same ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface startup_link_if;
  import startup_pkg::*;
  seq_clk_e clk_sel;
  logic     step;
  logic     pipe_en;
  logic     pin_in;
  logic     complete_seen;

  modport tick (input clk_sel, output step);
  modport cin  (input pipe_en, input pin_in, output complete_seen);
  modport seq  (output clk_sel, input step, output pipe_en, output pin_in,
                input complete_seen);
endinterface : startup_link_if
`default_nettype wire

//--- step_source_select.sv
/*
  Picks the selected start-up clock and turns its rising edge into a step.
  Assumes the three clock sources are levels synchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module step_source_select
  import startup_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     reset,
  input  wire logic     config_clock,
  input  wire logic     fabric_clock_source,
  input  wire logic     jtag_tck,
  startup_link_if.tick  link
);
  logic src;
  logic src_q;

  always_comb
  begin
    case (link.clk_sel)
      seq_clk_config: src = config_clock;
      seq_clk_fabric: src = fabric_clock_source;
      seq_clk_jtag:   src = jtag_tck;
      default:        src = config_clock;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      src_q <= 1'b0;
    else
      src_q <= src;
  end

  assign link.step = src & ~src_q;
endmodule : step_source_select
`default_nettype wire

//--- complete_input_stage.sv
/*
  Completion-pin input path, direct or through one register stage.
  Assumes the pin level is synchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module complete_input_stage
(
  input  wire logic    ref_clk,
  input  wire logic    reset,
  startup_link_if.cin  link
);
  logic pin_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pin_q <= 1'b0;
    else
      pin_q <= link.pin_in;
  end

  assign link.complete_seen = link.pipe_en ? pin_q : link.pin_in;
endmodule : complete_input_stage
`default_nettype wire

//--- config_startup_sequencer.sv
/*
  Start-up sequencer: counts phases on the selected start-up clock, releases the
  completion pin, the output hold and the global write enable at programmed phases.
  Assumes settings are applied with load_settings before start, and that the
  completion line is wired-AND with a pull-up among the devices of the chain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "startup_defs.svh"
module config_startup_sequencer
  import startup_pkg::*;
#(
  parameter int N_CLKMGR = 4
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  config_clock,
  input  wire logic                  fabric_clock_source,
  input  wire logic                  jtag_tck,
  input  wire seq_clk_e              sequencer_clock_select,
  input  wire logic                  load_settings,
  input  wire logic [`PHASE_W-1:0]   write_enable_phase_sel,
  input  wire logic [`PHASE_W-1:0]   output_release_phase_sel,
  input  wire logic [`PHASE_W-1:0]   complete_phase_sel,
  input  wire logic [`PHASE_W-1:0]   lock_wait_phase_sel,
  input  wire logic                  complete_active_drive,
  input  wire logic                  complete_input_pipeline,
  input  wire logic                  start,
  input  wire logic [N_CLKMGR-1:0]   clock_lock_flag,
  input  wire logic [N_CLKMGR-1:0]   lock_wait_enable,
  input  wire logic                  complete_pin_in,
  output logic                       complete_pin_out,
  output logic                       complete_pin_oe,
  output logic                       global_output_hold,
  output logic                       global_write_enable,
  output logic                       block_ram_enable,
  output logic [`PHASE_W-1:0]        phase,
  output logic                       startup_done
);
  startup_link_if link ();

  seq_state_e          state_q;
  logic [`PHASE_W-1:0] phase_q;
  logic [`PHASE_W-1:0] we_sel_q;
  logic [`PHASE_W-1:0] or_sel_q;
  logic [`PHASE_W-1:0] cp_sel_q;
  logic [`PHASE_W-1:0] lock_sel_q;
  seq_clk_e            clk_sel_q;
  logic                active_q;
  logic                pipe_q;
  logic                cp_released_q;
  logic                hold_q;
  logic                we_q;
  logic                bram_q;
  logic                done_q;
  logic                all_clock_lock_flag;
  logic                lock_stall;
  logic                done_stall;
  logic                advance;
  logic                or_fire;
  logic                we_fire;

  // A programmed phase code fires when the counter stands on it
  function automatic logic phase_hit(input logic [`PHASE_W-1:0] ph,
                                     input logic [`PHASE_W-1:0] sel);
    phase_hit = (sel != `SEL_WAIT_DONE) && (ph == sel);
  endfunction : phase_hit

  // Selector update, keeping the old value for the retain code
  function automatic logic [`PHASE_W-1:0] sel_update(input logic [`PHASE_W-1:0] cur,
                                                     input logic [`PHASE_W-1:0] nxt);
    sel_update = (nxt == `SEL_KEEP) ? cur : nxt;
  endfunction : sel_update

  assign link.clk_sel = clk_sel_q;
  assign link.pipe_en = pipe_q;
  assign link.pin_in  = complete_pin_in;

  step_source_select u_step
  (
    .ref_clk             (ref_clk),
    .reset               (reset),
    .config_clock        (config_clock),
    .fabric_clock_source (fabric_clock_source),
    .jtag_tck            (jtag_tck),
    .link                (link)
  );

  complete_input_stage u_cin
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .link    (link)
  );

  // Settings
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      we_sel_q   <= `WE_PHASE_RESET;
      or_sel_q   <= `OR_PHASE_RESET;
      cp_sel_q   <= `CP_PHASE_RESET;
      lock_sel_q <= `LOCK_SEL_RESET;
      clk_sel_q  <= seq_clk_config;
      active_q   <= 1'b0;
      pipe_q     <= 1'b0;
    end
    else if (load_settings && state_q == st_idle)
    begin
      we_sel_q   <= sel_update(we_sel_q, write_enable_phase_sel);
      or_sel_q   <= sel_update(or_sel_q, output_release_phase_sel);
      cp_sel_q   <= (complete_phase_sel == `SEL_KEEP || complete_phase_sel == `PHASE_END)
                    ? cp_sel_q : complete_phase_sel;
      lock_sel_q <= lock_wait_phase_sel;
      clk_sel_q  <= sequencer_clock_select;
      active_q   <= complete_active_drive;
      pipe_q     <= complete_input_pipeline;
    end
  end

  assign all_clock_lock_flag = &(clock_lock_flag | ~lock_wait_enable);
  assign lock_stall = (lock_sel_q != `LOCK_NO_WAIT) && (phase_q == lock_sel_q)
                      && !all_clock_lock_flag;
  assign done_stall = (phase_q == `PHASE_LAST_SEL) && !link.complete_seen
                      && ((we_sel_q == `SEL_WAIT_DONE && !we_q)
                          || (or_sel_q == `SEL_WAIT_DONE && hold_q));
  assign advance    = (state_q == st_run) && link.step && !lock_stall && !done_stall;
  assign or_fire    = (state_q == st_run) && link.step && !lock_stall
                      && (or_sel_q == `SEL_WAIT_DONE ? link.complete_seen
                          : phase_hit(phase_q, or_sel_q));
  assign we_fire    = (state_q == st_run) && link.step && !lock_stall
                      && (we_sel_q == `SEL_WAIT_DONE ? link.complete_seen
                          : phase_hit(phase_q, we_sel_q));

  // Sequence state and phase counter
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= st_idle;
      phase_q <= `PHASE_FIRST;
    end
    else
    begin
      case (state_q)
        st_idle:
        begin
          phase_q <= `PHASE_FIRST;
          if (start)
            state_q <= st_run;
        end
        st_run:
        begin
          if (advance && phase_q != `PHASE_END)
            phase_q <= phase_q + 3'h1;
          if (phase_q == `PHASE_END && !hold_q && we_q && cp_released_q)
            state_q <= st_user;
        end
        st_user:
          state_q <= st_user;
        default:
          state_q <= st_idle;
      endcase
    end
  end

  // Completion pin release
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cp_released_q <= 1'b0;
    else if (state_q == st_run && link.step && !lock_stall && phase_hit(phase_q, cp_sel_q))
      cp_released_q <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      complete_pin_out <= 1'b0;
      complete_pin_oe  <= 1'b1;
    end
    else if (cp_released_q)
    begin
      complete_pin_out <= active_q;
      complete_pin_oe  <= active_q;
    end
    else
    begin
      complete_pin_out <= 1'b0;
      complete_pin_oe  <= 1'b1;
    end
  end

  // Output hold and write enable
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hold_q <= 1'b1;
    else if (or_fire)
      hold_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      we_q   <= 1'b0;
      bram_q <= 1'b0;
    end
    else if (we_fire)
    begin
      we_q   <= 1'b1;
      bram_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      done_q <= 1'b0;
    else
      done_q <= (state_q == st_user);
  end

  assign global_output_hold  = hold_q;
  assign global_write_enable = we_q;
  assign block_ram_enable    = bram_q;
  assign phase               = phase_q;
  assign startup_done        = done_q;
endmodule : config_startup_sequencer
`default_nettype wire

//--- startup_asserts.sv
/* Port checker of the start-up sequencer.
   Assumes the setting inputs stay steady while a start-up runs. */
`timescale 1ns/10ps
`default_nettype none
`include "startup_defs.svh"
module startup_asserts
#(
  parameter int N_CLKMGR = 4
)
(
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic [`PHASE_W-1:0] write_enable_phase_sel,
  input wire logic [`PHASE_W-1:0] output_release_phase_sel,
  input wire logic [`PHASE_W-1:0] complete_phase_sel,
  input wire logic [`PHASE_W-1:0] lock_wait_phase_sel,
  input wire logic                complete_active_drive,
  input wire logic [N_CLKMGR-1:0] clock_lock_flag,
  input wire logic [N_CLKMGR-1:0] lock_wait_enable,
  input wire logic                complete_pin_in,
  input wire logic                complete_pin_out,
  input wire logic                complete_pin_oe,
  input wire logic                global_output_hold,
  input wire logic                global_write_enable,
  input wire logic                block_ram_enable,
  input wire logic [`PHASE_W-1:0] phase,
  input wire logic                startup_done
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_WE_BRAM:
    assert property (global_write_enable == block_ram_enable) else $error("bram");
  AST_HOLD_STANDS:
    assert property ($fell(global_output_hold) |=> !global_output_hold [*8]) else $error("hold");
  AST_PHASE_STEP:
    assert property ($changed(phase) |-> phase == $past(phase) + 3'h1) else $error("phase");
  AST_LOCK_STALL:
    assert property (lock_wait_phase_sel != `LOCK_NO_WAIT && phase == lock_wait_phase_sel
      && !(&(clock_lock_flag | ~lock_wait_enable)) |=> $stable(phase)) else $error("lock");
  AST_WAIT_WE:
    assert property (write_enable_phase_sel == `SEL_WAIT_DONE && !global_write_enable
      && !complete_pin_in && !$past(complete_pin_in) |=> !global_write_enable) else $error("we");
  AST_WAIT_HOLD:
    assert property (output_release_phase_sel == `SEL_WAIT_DONE && global_output_hold
      && !complete_pin_in && !$past(complete_pin_in) |=> global_output_hold) else $error("hz");
  AST_PIN_PASSIVE:
    assert property ($fell(complete_pin_oe) |-> !complete_active_drive
      && $past(phase, 2) == complete_phase_sel) else $error("pin off");
  AST_PIN_ACTIVE:
    assert property ($rose(complete_pin_out) |-> complete_pin_oe && complete_active_drive
      && $past(phase, 2) == complete_phase_sel) else $error("pin on");
  AST_DONE_END:
    assert property ($rose(startup_done) |-> $past(phase) == `PHASE_END && global_write_enable
      && !global_output_hold) else $error("done");
  cover property (startup_done);
  cover property ($fell(complete_pin_oe));
  cover property (write_enable_phase_sel == `SEL_WAIT_DONE && $rose(global_write_enable));
endmodule : startup_asserts
`default_nettype wire

//--- chain_peer.sv
/* Other devices on the shared completion line, plus its pull-up.
   Assumes the bench says when those devices let go of the line. */
`timescale 1ns/10ps
`default_nettype none
module chain_peer
(
  input  wire logic dut_out,
  input  wire logic dut_oe,
  input  wire logic peer_hold,
  output logic      line
);
  // Any party driving low wins, else the pull-up lifts the line
  assign line = !((dut_oe && !dut_out) || peer_hold);
endmodule : chain_peer
`default_nettype wire

//--- tb_top.sv
/* Random and corner-case bench of the start-up sequencer.
   Assumes package, checker and chain peer are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "startup_defs.svh"
module tb_top
  import startup_pkg::*;
;
  localparam int N_CLKMGR = 4;
  logic                ref_clk, reset, load, start, act, pipe, peer_hold, line;
  logic                oe, out, hold, we, bram, done, e_we, e_or, e_cp;
  logic [2:0]          src, we_s, or_s, cp_s, lk_s, ph, phase;
  logic [N_CLKMGR-1:0] flags, en;
  logic [31:0]         rng;
  seq_clk_e            csel;
  int                  error_cnt, cmp_count;

  config_startup_sequencer #(.N_CLKMGR(N_CLKMGR)) dut
  (
    .ref_clk(ref_clk), .reset(reset), .config_clock(src[0]), .fabric_clock_source(src[1]),
    .jtag_tck(src[2]), .sequencer_clock_select(csel), .load_settings(load),
    .write_enable_phase_sel(we_s), .output_release_phase_sel(or_s), .complete_phase_sel(cp_s),
    .lock_wait_phase_sel(lk_s), .complete_active_drive(act), .complete_input_pipeline(pipe),
    .start(start), .clock_lock_flag(flags), .lock_wait_enable(en), .complete_pin_in(line),
    .complete_pin_out(out), .complete_pin_oe(oe), .global_output_hold(hold),
    .global_write_enable(we), .block_ram_enable(bram), .phase(phase), .startup_done(done)
  );
  chain_peer peer (.dut_out(out), .dut_oe(oe), .peer_hold(peer_hold), .line(line));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  function automatic logic [7:0] exp_bits();
    return {ph, !e_or, e_we, e_we, !e_cp || act, e_cp && act};
  endfunction : exp_bits

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic step();
    logic seen;
    logic ok;
    @(negedge ref_clk);
    seen = e_cp && !peer_hold;
    void'(rnd());
    if (rng[1:0] == 2'h0)
      peer_hold = 0;
    seen = seen || (e_cp && !peer_hold && !pipe);
    flags = rng[N_CLKMGR+7:8];
    en = rng[N_CLKMGR+15:16];
    src = rng[4:2] | (3'h1 << csel);
    ok = lk_s == `LOCK_NO_WAIT || ph != lk_s || &(flags | ~en);
    if (ok && ph != `PHASE_END)
    begin
      e_we |= seen && we_s == `SEL_WAIT_DONE;
      e_or |= seen && or_s == `SEL_WAIT_DONE;
      // Phase releases also fire on a step swallowed by the completion wait
      e_cp |= ph == cp_s;
      e_or |= ph == or_s;
      e_we |= ph == we_s;
      if (ph != 3'h6 || !((we_s == `SEL_WAIT_DONE && !e_we) || (or_s == `SEL_WAIT_DONE && !e_or)))
        ph++;
    end
    @(negedge ref_clk);
    src = rng[7:5] & ~(3'h1 << csel);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({phase, hold, we, bram, oe, out}, exp_bits());
    if (rng[20])
      peer_hold = 0;
    @(posedge ref_clk);
  endtask : step

  task automatic run(input logic cfg);
    logic [8:0] keep;
    @(negedge ref_clk);
    reset = 1;
    peer_hold = 1;
    {e_we, e_or, e_cp, ph} = 6'h0;
    repeat (5) @(negedge ref_clk);
    reset = 0;
    if (cfg)
    begin
      load = 1;
      keep = {we_s, or_s, cp_s};
      @(negedge ref_clk);
      {we_s, or_s, cp_s} = {6'h0, rng[9] ? 3'h7 : 3'h0};
      @(negedge ref_clk);
      {we_s, or_s, cp_s} = keep;
      load = 0;
    end
    src = 3'h7;
    @(negedge ref_clk);
    chk({phase, hold, we, bram, oe, out}, exp_bits());
    {src, start} = 4'h1;
    @(negedge ref_clk);
    {start, load, act, pipe} = {2'h1, !act, !pipe};
    @(negedge ref_clk);
    {load, act, pipe} = {1'b0, !act, !pipe};
    for (int i = 0; i < 80 && ph != `PHASE_END; i++)
      step();
    step();
    @(negedge ref_clk);
    chk({7'h0, done}, 8'h01);
  endtask : run

  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #800000;
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    {load, start, act, pipe, peer_hold, src, flags, en} = '0;
    reset = 1;
    {we_s, or_s, cp_s, lk_s} = {`WE_PHASE_RESET, `OR_PHASE_RESET, `CP_PHASE_RESET, `LOCK_SEL_RESET};
    csel = seq_clk_config;
    error_cnt = 0;
    cmp_count = 0;
    rng = 32'hA328;
    run(1'b0);
    for (int r = 0; r < 30; r++)
    begin
      void'(rnd());
      we_s = r == 0 ? 3'h7 : rng[2:0] % 3'h7 + 3'h1;
      or_s = r == 0 ? 3'h7 : rng[5:3] % 3'h7 + 3'h1;
      cp_s = rng[8:6] % 3'h6 + 3'h1;
      lk_s = rng[11:9];
      csel = seq_clk_e'(rng[13:12] % 2'h3);
      {act, pipe} = r == 0 ? 2'h1 : rng[15:14];
      run(1'b1);
    end
    give_verdict();
  end
endmodule : tb_top

bind config_startup_sequencer startup_asserts #(.N_CLKMGR(N_CLKMGR)) chk_i
(
  .ref_clk, .reset, .write_enable_phase_sel, .output_release_phase_sel, .complete_phase_sel,
  .lock_wait_phase_sel, .complete_active_drive, .clock_lock_flag, .lock_wait_enable,
  .complete_pin_in, .complete_pin_out, .complete_pin_oe, .global_output_hold,
  .global_write_enable, .block_ram_enable, .phase, .startup_done
);
`default_nettype wire
